// [sadc_consts.svh]
/*
 * Constants for the converter serial readout and mode control block.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SADC_FRAME_BITS 16
`define SADC_LEAD_ZEROS 4
`define SADC_PD_EDGE_LO 5'h02
`define SADC_PD_EDGE_HI 5'h0A
`define SADC_FULL_EDGE 5'h10
`define SADC_RES_12 2'h0
`define SADC_RES_10 2'h1
`define SADC_RES_8 2'h2

// ----------------------------------------
// Rates
// ----------------------------------------
`define SADC_SCLK_MHZ 20
`define SADC_RATE_KSPS 1000
`define SADC_SCLK_PER_CONV 16

`endif

// [sadc_pkg.sv]
/*
 * Types for the converter serial readout and mode control block.
 * Assumes the constants header sits in the same folder.
 */
package sadc_pkg;
    typedef enum logic [3:0] {
        SADC_IDLE = 4'h1,
        SADC_CONV = 4'h2,
        SADC_DONE = 4'h4,
        SADC_ABORT = 4'h8
    } sadc_state_t;

    typedef enum logic {
        SADC_MODE_NORMAL = 1'b0,
        SADC_MODE_PDOWN = 1'b1
    } sadc_mode_t;
endpackage

// [sadc_sar_core.sv]
/*
 * Successive-approximation search: one trial bit per serial clock step.
 * Assumes the caller pulses i_step on serial clock falling edges and holds
 * i_cmp_high as the comparator answer for the present trial.
 */
`timescale 1ns/10ps
`include "sadc_consts.svh"

module sadc_sar_core
    import sadc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    // Control
    input wire logic i_start,
    input wire logic i_step,
    input wire logic i_cmp_high,
    // Result
    output logic [11:0] o_trial,
    output logic [11:0] o_code,
    output logic o_done
);
    logic [11:0] code;
    logic [11:0] mask;
    logic done;
    logic [11:0] next_code;
    logic [11:0] next_mask;
    logic next_done;

    // ----------------------------------------
    // Search
    // ----------------------------------------
    always_comb begin
        next_code = code;
        next_mask = mask;
        next_done = done;
        if (i_start) begin
            next_code = 12'h800;
            next_mask = 12'h800;
            next_done = 1'b0;
        end else if (i_step && !done) begin
            // Keep trial bit when input is above it, then try next lower bit
            next_code = (i_cmp_high ? code : (code & ~mask)) | (mask >> 1);
            next_mask = mask >> 1;
            if (mask == 12'h001) begin
                next_code = i_cmp_high ? code : (code & ~mask);
                next_done = 1'b1; // Balanced: code is final
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            code <= 12'h000;
            mask <= 12'h000;
            done <= 1'b0;
        end else if (i_ce) begin
            code <= next_code;
            mask <= next_mask;
            done <= next_done;
        end
    end

    assign o_trial = code;
    assign o_code = code; // Straight binary, zero scale is all zeros
    assign o_done = done;
endmodule // sadc_sar_core

// [sadc_readout.sv]
/*
 * Serial readout and power mode control of a small SAR converter.
 * Assumes chip select and serial clock are synchronous inputs sampled on
 * i_clk_sys, which must run well above the serial clock (20 MHz nominal).
 */
`timescale 1ns/10ps
`include "sadc_consts.svh"

module sadc_readout
    import sadc_pkg::*;
#(
    parameter logic [1:0] RES_SEL = `SADC_RES_12
) (
    // Clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    // Serial pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    output logic o_serial_result_out,
    output logic o_serial_result_out_oe,
    // Analog front end
    input wire logic i_cmp_high,
    output logic [11:0] o_dac_trial,
    output logic o_sample_hold,
    // Status
    output logic o_power_down,
    output logic o_conv_done
);
    localparam int SCLK_PER_US = `SADC_SCLK_MHZ * 1000 / `SADC_RATE_KSPS;

    sadc_state_t state;
    sadc_state_t next_state;
    sadc_mode_t mode;
    sadc_mode_t next_mode;
    logic cs_n_q;
    logic sclk_q;
    logic [4:0] edge_cnt;
    logic [4:0] next_edge_cnt;
    logic live;
    logic next_live;
    logic [15:0] word_now;
    logic sdo;
    logic next_sdo;
    logic oe;
    logic next_oe;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;
    logic sar_step;
    logic [11:0] sar_code;
    logic sar_done;

    // Build the padded frame word for the chosen resolution
    function automatic logic [15:0] frame_word(input logic [1:0] res, input logic [11:0] code);
        case (res)
            `SADC_RES_10: frame_word = {4'h0, code[11:2], 2'h0};
            `SADC_RES_8: frame_word = {4'h0, code[11:4], 4'h0};
            default: frame_word = {4'h0, code};
        endcase
    endfunction

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cs_n_q <= 1'b1;
            sclk_q <= 1'b1;
        end else if (i_ce) begin
            cs_n_q <= i_cs_n;
            sclk_q <= i_sclk;
        end
    end

    assign cs_fall = cs_n_q && !i_cs_n;
    assign cs_rise = !cs_n_q && i_cs_n;
    assign sclk_fall = sclk_q && !i_sclk && !i_cs_n;

    // The step count fits 12 trials into edges 3..14 of 16, so a 20 MHz
    // clock finishes one conversion per microsecond of frame.
    assign sar_step = sclk_fall && (state == SADC_CONV) && (edge_cnt >= 5'h02) && (edge_cnt < 5'h0E);

    // Resolution sets the transfer grid; the 8-bit variant uses whole-step
    // transitions, which the analog trial offset provides.
    sadc_sar_core u_sar (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_start(cs_fall && mode == SADC_MODE_NORMAL),
        .i_step(sar_step),
        .i_cmp_high(i_cmp_high),
        .o_trial(o_dac_trial),
        .o_code(sar_code),
        .o_done(sar_done)
    );

    // A frame begun in power-down starts no new search and leaves live low, so its word is all zeros
    assign word_now = live ? frame_word(RES_SEL, sar_code) : 16'h0000;

    // ----------------------------------------
    // Frame and mode control
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_mode = mode;
        next_edge_cnt = edge_cnt;
        next_live = live;
        next_sdo = sdo;
        next_oe = oe;
        case (state)
            SADC_IDLE: begin
                next_oe = 1'b0;
                next_sdo = 1'b0;
                if (cs_fall) begin
                    next_state = SADC_CONV;
                    next_edge_cnt = 5'h00;
                    next_oe = 1'b1;
                    next_live = (mode == SADC_MODE_NORMAL);
                end
            end
            SADC_CONV: begin
                if (cs_rise) begin
                    next_oe = 1'b0;
                    next_state = SADC_IDLE;
                    if (edge_cnt >= `SADC_PD_EDGE_LO && edge_cnt < `SADC_PD_EDGE_HI) begin
                        next_mode = SADC_MODE_PDOWN;
                    end else if (edge_cnt < `SADC_PD_EDGE_LO) begin
                        next_mode = mode; // Glitch guard, keeps mode
                    end else begin
                        next_mode = SADC_MODE_NORMAL;
                    end
                    if (mode == SADC_MODE_PDOWN && edge_cnt < `SADC_PD_EDGE_HI) begin
                        next_mode = SADC_MODE_PDOWN; // Short frame stays down
                    end
                end else if (sclk_fall) begin
                    next_edge_cnt = edge_cnt + 5'h01;
                    // Each result bit settles two falls before it is due, so
                    // the word is read live instead of loaded once.
                    next_sdo = word_now[4'hF - edge_cnt[3:0]];
                    if (edge_cnt == 5'h09 && mode == SADC_MODE_PDOWN) begin
                        next_mode = SADC_MODE_NORMAL; // Held to tenth edge
                    end
                    if (edge_cnt == `SADC_FULL_EDGE - 5'h01) begin
                        next_state = SADC_DONE;
                    end
                end
            end
            SADC_DONE: begin
                if (cs_rise || sclk_fall) begin
                    next_oe = 1'b0; // Word complete, release the line
                    next_sdo = 1'b0;
                end
                if (cs_rise) begin
                    next_state = SADC_IDLE;
                end
            end
            SADC_ABORT: begin
                next_state = SADC_IDLE;
                next_oe = 1'b0;
            end
            default: begin
                next_state = SADC_IDLE;
                next_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state <= SADC_IDLE;
            mode <= SADC_MODE_NORMAL;
            edge_cnt <= 5'h00;
            live <= 1'b0;
            sdo <= 1'b0;
            oe <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            mode <= next_mode;
            edge_cnt <= next_edge_cnt;
            live <= next_live;
            sdo <= next_sdo;
            oe <= next_oe;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_serial_result_out = sdo;
    assign o_serial_result_out_oe = oe && !i_cs_n;
    assign o_sample_hold = (state == SADC_CONV) && live;
    assign o_power_down = (mode == SADC_MODE_PDOWN);
    assign o_conv_done = sar_done;
endmodule // sadc_readout

// [sadc_readout_checker.sv]
/*
 * Assertions on the ports of the converter readout block.
 * Assumes chip select and serial clock are sampled on i_clk_sys, as the block does.
 */
`timescale 1ns/10ps
module sadc_readout_checker
    import sadc_pkg::*;
#(
    parameter logic [1:0] RES_SEL = 2'h0
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    // Serial pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic o_serial_result_out,
    input wire logic o_serial_result_out_oe,
    // Front end and status
    input wire logic i_cmp_high,
    input wire logic [11:0] o_dac_trial,
    input wire logic o_sample_hold,
    input wire logic o_power_down,
    input wire logic o_conv_done
);
    // ----
    // Edge tracking
    // ----
    logic cs_q, sck_q, next_cs_q, next_sck_q, cs_fall, cs_rise, sck_fall;
    logic [4:0] n_fall, next_n_fall;
    assign cs_fall = cs_q & ~i_cs_n;
    assign cs_rise = ~cs_q & i_cs_n;
    assign sck_fall = sck_q & ~i_sclk & ~i_cs_n;
    always_comb begin
        next_cs_q = i_ce ? i_cs_n : cs_q;
        next_sck_q = i_ce ? i_sclk : sck_q;
        next_n_fall = n_fall;
        if (i_ce && cs_fall) begin
            next_n_fall = 5'h00;
        end else if (i_ce && sck_fall && n_fall != 5'h1F) begin
            next_n_fall = n_fall + 5'h01;
        end
    end
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cs_q <= 1'b1;
            sck_q <= 1'b1;
            n_fall <= 5'h00;
        end else begin
            cs_q <= next_cs_q;
            sck_q <= next_sck_q;
            n_fall <= next_n_fall;
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    oe_on_select_a: assert property (cs_fall |-> ##[1:2] o_serial_result_out_oe)
        else $error("line not driven after select");
    oe_off_deselect_a: assert property (i_cs_n |-> !o_serial_result_out_oe)
        else $error("line driven while deselected");
    lead_zeros_a: assert property (sck_fall && n_fall < 5'h04 |-> ##3 !o_serial_result_out)
        else $error("leading bit not zero");
    pd_enter_a: assert property (cs_rise && n_fall inside {[5'h02:5'h09]} |-> ##3 o_power_down)
        else $error("no power-down after early rise");
    mode_keep_a: assert property (cs_rise && n_fall < 5'h02 |=> $stable(o_power_down) [*3])
        else $error("mode changed on glitch frame");
    stay_up_a: assert property (cs_rise && n_fall >= 5'h0A |-> ##3 !o_power_down)
        else $error("powered down after late rise");
    wake_a: assert property (sck_fall && n_fall == 5'h09 |-> ##3 !o_power_down)
        else $error("no wake at tenth fall");
    hold_off_pd_a: assert property (o_sample_hold |-> !o_power_down)
        else $error("converting while powered down");
    cover property (cs_rise && n_fall inside {[5'h02:5'h09]});
    cover property (cs_rise && n_fall == 5'h10);
    cover property (o_power_down && sck_fall && n_fall == 5'h09);
endmodule // sadc_readout_checker

bind sadc_readout sadc_readout_checker #(.RES_SEL(RES_SEL)) sadc_readout_checker_inst (.*);

// [sadc_host_model.sv]
/*
 * Host model: frames chip select and the serial clock and captures the word.
 * Assumes the bench floats i_serial_result_out to z whenever the converter does not drive.
 */
`timescale 1ns/10ps
module sadc_host_model (
    // Clock
    input wire logic i_clk_sys,
    // Serial pins
    output logic o_cs_n,
    output logic o_sclk,
    input wire logic i_serial_result_out
);
    // Serial clock idles high and stands still outside frames
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
    end
    // Five system cycles per serial period gives 20 MHz, one word per conversion
    task automatic xfer(input int nf, output logic [15:0] w);
        w = 16'h0000;
        @(posedge i_clk_sys);
        #1 o_cs_n = 1'b0;
        repeat (2) @(posedge i_clk_sys);
        for (int k = 1; k <= nf; k++) begin
            #1 o_sclk = 1'b0;
            repeat (3) @(posedge i_clk_sys);
            #1 w[16 - k] = i_serial_result_out;
            o_sclk = 1'b1;
            repeat (2) @(posedge i_clk_sys);
        end
        #1 o_cs_n = 1'b1;
    endtask
endmodule // sadc_host_model

// [sadc_readout_test.sv]
/*
 * Self-checking bench for the converter readout block.
 * Assumes the host model paces frames and the bench plays an ideal comparator.
 */
`timescale 1ns/10ps
module sadc_readout_test;
    logic i_clk_sys, i_rst, cmp, sdo, oe, pd, done, hold;
    logic [11:0] trial, vin;
    logic [15:0] w, ex;
    wire cs_n, sclk, serial_result_out;
    int err_total, cmp_count, pd_mdl, st, nf;
    int nf_list[$] = '{16, 16, 1, 5, 2, 9, 13, 16, 3, 10, 0, 16, 2, 1, 16, 16};
    assign serial_result_out = oe ? sdo : 1'bz;
    assign cmp = (vin >= trial);
    sadc_readout #(.RES_SEL(2'h0)) sadc_readout_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(1'b1),
        .i_cs_n(cs_n), .i_sclk(sclk), .o_serial_result_out(sdo), .o_serial_result_out_oe(oe),
        .i_cmp_high(cmp), .o_dac_trial(trial), .o_sample_hold(hold), .o_power_down(pd), .o_conv_done(done));
    sadc_host_model sadc_host_model_inst (.i_clk_sys(i_clk_sys), .o_cs_n(cs_n), .o_sclk(sclk), .i_serial_result_out(serial_result_out));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_total++;
        report_and_stop();
    end
    initial begin
        i_rst = 1'b1;
        vin = 12'h000;
        void'($urandom(32'hBA2D));
        repeat (5) @(posedge i_clk_sys);
        #1 i_rst = 1'b0;
        check("drive_enable", oe, 16'h0000);
        // A frame that starts powered down carries an all-zero word
        foreach (nf_list[i]) begin
            nf = nf_list[i];
            st = pd_mdl;
            vin = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
            ex = st ? 16'h0000 : {4'h0, vin};
            sadc_host_model_inst.xfer(nf, w);
            if (nf >= 10) begin
                pd_mdl = 0;
            end else if (nf >= 2) begin
                pd_mdl = 1;
            end
            repeat ($urandom_range(3, 6)) @(posedge i_clk_sys);
            #1;
            check("serial_word", w, ex & ~(16'hFFFF >> nf));
            check("power_down", pd, 16'(pd_mdl));
            check("drive_enable", oe, 16'h0000);
            check("sample_hold", hold, 16'h0000);
            if (nf == 16 && st == 0) begin
                check("conv_done", done, 16'h0001);
            end
        end
        report_and_stop();
    end
endmodule // sadc_readout_test
